// File: pkg/sdrtp_defines.svh
// Constants for the SDRAM timing parameter set: register offsets, field
// positions, reset values and encodings of the memory type input.
// Assumes it is included by its bare name ahead of the package and module.
//
// Functional notes
// - Refresh is requested once every refresh period cycles, a 15-bit field reset to 0xA60.
// - Timing registers are reachable only in the configuration or low-power state.
// - Returned read data is captured a programmed 3-bit latency after the read command.
// - The latency-offset bit adds half a memory clock to the read latency when set.
// - In mobile-DDR or single-data-rate mode the half-cycle offset is forced to zero.
// - A mode-register command blocks the next command for a 7-bit count, reset to two.
// - A row stays open a 4-bit count after activation before precharge, reset to seven.
// - Two activates to one bank are spaced by a 4-bit count, reset to eleven.
// - Activate to column command waits a 3-bit memory count and a 3-bit schedule count plus three.
// - After auto-refresh no command issues for a 5-bit memory count and a 5-bit schedule count plus three.
// - Precharge to activate waits a 3-bit memory count and a 3-bit schedule count plus three.
// - Activates to two different banks are spaced by a 4-bit count, reset to two.
// - Last write data to precharge waits a 3-bit write recovery count, reset to three.
`ifndef SDRTP_DEFINES_SVH
`define SDRTP_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SDRTP_OFF_REFRESH 8'h10
`define SDRTP_OFF_LATENCY 8'h14
`define SDRTP_OFF_DQSS 8'h18
`define SDRTP_OFF_MRD 8'h1C
`define SDRTP_OFF_RAS 8'h20
`define SDRTP_OFF_RC 8'h24
`define SDRTP_OFF_RCD 8'h28
`define SDRTP_OFF_RFC 8'h2C
`define SDRTP_OFF_RP 8'h30
`define SDRTP_OFF_RRD 8'h34
`define SDRTP_OFF_WR 8'h38
`define SDRTP_OFF_STATUS 8'h80

// ----------------------------------------------------------------------
// reset values, field positions and encodings
// ----------------------------------------------------------------------
`define SDRTP_RST_REFRESH 15'h0A60
`define SDRTP_RST_LATENCY 4'h6
`define SDRTP_RST_DQSS 2'h1
`define SDRTP_RST_MRD 7'h02
`define SDRTP_RST_RAS 4'h7
`define SDRTP_RST_RC 4'hB
`define SDRTP_RST_RCD 6'h1D
`define SDRTP_RST_RFC 10'h212
`define SDRTP_RST_RP 6'h1D
`define SDRTP_RST_RRD 4'h2
`define SDRTP_RST_WR 3'h3
`define SDRTP_LAT_HALF_BIT 0
`define SDRTP_LAT_LSB 1
`define SDRTP_RCD_SCHED_LSB 3
`define SDRTP_RP_SCHED_LSB 3
`define SDRTP_RFC_SCHED_LSB 5
`define SDRTP_SCHED_BIAS 8'h03
`define SDRTP_MEM_SDR 3'h0
`define SDRTP_MEM_DDR 3'h1
`define SDRTP_MEM_LPDDR 3'h3
`define SDRTP_PIPE_LEN 8
`define SDRTP_BANKS 4

`endif

// File: pkg/sdrtp_pkg.sv
// Types shared by the timing parameter set and its surroundings.
// Assumes sdrtp_defines.svh is available on the include path.
`include "sdrtp_defines.svh"
package sdrtp_pkg;
  // controller operating state, driven by the command sequencer
  typedef enum logic [1:0] {
    SDRTP_ST_CONFIG, SDRTP_ST_READY, SDRTP_ST_PAUSED, SDRTP_ST_LOW_POWER
  } sdrtp_ctrl_state_t;
  // one-cycle command issue pulses with their target bank
  typedef struct packed {
    logic activate;
    logic read;
    logic write_last;
    logic precharge;
    logic precharge_all;
    logic refresh;
    logic mode_reg;
    logic [1:0] bank;
  } sdrtp_cmd_t;
  // permission levels toward the sequencer, two global bits and five bits per bank
  typedef struct packed {
    logic any_ok;
    logic sched_any_ok;
    logic [`SDRTP_BANKS-1:0] activate_ok;
    logic [`SDRTP_BANKS-1:0] column_ok;
    logic [`SDRTP_BANKS-1:0] precharge_ok;
    logic [`SDRTP_BANKS-1:0] sched_activate_ok;
    logic [`SDRTP_BANKS-1:0] sched_column_ok;
  } sdrtp_gate_t;
endpackage

// File: logic/sdrtp_timing.sv
// Timing parameter registers and spacing counters of the SDRAM controller.
// Assumes the sequencer drives i_cmd pulses on the same clock and reads
// o_gate before issuing; i_ctrl_state and i_memory_type are synchronous.
`include "sdrtp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sdrtp_timing (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_address,
  input wire logic [31:0] i_write_data,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_read_data,
  input wire sdrtp_pkg::sdrtp_ctrl_state_t i_ctrl_state,
  input wire logic [2:0] i_memory_type,
  input wire sdrtp_pkg::sdrtp_cmd_t i_cmd,
  output sdrtp_pkg::sdrtp_gate_t o_gate,
  output logic o_refresh_request,
  output logic o_capture,
  output logic o_capture_half,
  output logic [1:0] o_write_strobe_delay
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------

  // a spacing of n cycles keeps its counter non-zero for n-1 cycles
  function automatic logic [7:0] span(input logic [7:0] n);
    span = (n == 8'h00) ? 8'h00 : n - 8'h01;
  endfunction

  // saturating decrement shared by all spacing counters
  function automatic logic [7:0] dec(input logic [7:0] c);
    dec = (c == 8'h00) ? 8'h00 : c - 8'h01;
  endfunction

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [14:0] refresh_period;
  logic [3:0] read_latency_setting;
  logic [1:0] write_strobe_delay;
  logic [6:0] mode_reg_cmd_time;
  logic [3:0] activate_to_precharge_min;
  logic [3:0] same_bank_activate_interval;
  logic [5:0] row_to_column_delay;
  logic [9:0] auto_refresh_cmd_time;
  logic [5:0] precharge_to_activate_delay;
  logic [3:0] cross_bank_activate_interval;
  logic [2:0] write_recovery_delay;

  logic access_ok;
  logic write_en;
  logic refresh_pending;
  logic [14:0] refresh_count;
  logic [`SDRTP_PIPE_LEN-1:0] read_pipe;
  logic half_offset;
  logic [2:0] latency;
  logic [2:0] capture_index;
  logic next_half;
  logic [7:0] mrd_cnt;
  logic [7:0] rfc_cnt;
  logic [7:0] sched_rfc_cnt;
  logic [7:0] rrd_cnt;
  logic [7:0] load_rcd_sched;
  logic [7:0] load_rp_sched;
  logic [7:0] load_rfc_sched;

  // outside configuration and low power the timers are live, so software
  // is kept off them rather than risk changing a spacing mid-count
  assign access_ok = (i_ctrl_state == sdrtp_pkg::SDRTP_ST_CONFIG) ||
                     (i_ctrl_state == sdrtp_pkg::SDRTP_ST_LOW_POWER);
  assign write_en = i_write && access_ok;

  // register writes, dropped silently when access is not allowed
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refresh_period <= `SDRTP_RST_REFRESH;
      read_latency_setting <= `SDRTP_RST_LATENCY;
      write_strobe_delay <= `SDRTP_RST_DQSS;
      mode_reg_cmd_time <= `SDRTP_RST_MRD;
      activate_to_precharge_min <= `SDRTP_RST_RAS;
      same_bank_activate_interval <= `SDRTP_RST_RC;
      row_to_column_delay <= `SDRTP_RST_RCD;
      auto_refresh_cmd_time <= `SDRTP_RST_RFC;
      precharge_to_activate_delay <= `SDRTP_RST_RP;
      cross_bank_activate_interval <= `SDRTP_RST_RRD;
      write_recovery_delay <= `SDRTP_RST_WR;
    end else if (write_en) begin
      unique case (i_address)
        `SDRTP_OFF_REFRESH: refresh_period <= i_write_data[14:0];
        `SDRTP_OFF_LATENCY: read_latency_setting <= i_write_data[3:0];
        `SDRTP_OFF_DQSS: write_strobe_delay <= i_write_data[1:0];
        `SDRTP_OFF_MRD: mode_reg_cmd_time <= i_write_data[6:0];
        `SDRTP_OFF_RAS: activate_to_precharge_min <= i_write_data[3:0];
        `SDRTP_OFF_RC: same_bank_activate_interval <= i_write_data[3:0];
        `SDRTP_OFF_RCD: row_to_column_delay <= i_write_data[5:0];
        `SDRTP_OFF_RFC: auto_refresh_cmd_time <= i_write_data[9:0];
        `SDRTP_OFF_RP: precharge_to_activate_delay <= i_write_data[5:0];
        `SDRTP_OFF_RRD: cross_bank_activate_interval <= i_write_data[3:0];
        `SDRTP_OFF_WR: write_recovery_delay <= i_write_data[2:0];
        default: ;
      endcase
    end
  end

  // read data stand one cycle after the strobe; reserved bits read zero
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_read_data <= 32'h0000_0000;
    end else begin
      o_read_data <= 32'h0000_0000;
      if (i_read && i_address == `SDRTP_OFF_STATUS) begin
        o_read_data <= {28'h0000000, half_offset, access_ok,
                        o_gate.any_ok, refresh_pending};
      end else if (i_read && access_ok) begin
        unique case (i_address)
          `SDRTP_OFF_REFRESH: o_read_data <= {17'h00000, refresh_period};
          `SDRTP_OFF_LATENCY: o_read_data <= {28'h0000000,
                                              read_latency_setting};
          `SDRTP_OFF_DQSS: o_read_data <= {30'h00000000, write_strobe_delay};
          `SDRTP_OFF_MRD: o_read_data <= {25'h0000000, mode_reg_cmd_time};
          `SDRTP_OFF_RAS: o_read_data <= {28'h0000000,
                                          activate_to_precharge_min};
          `SDRTP_OFF_RC: o_read_data <= {28'h0000000,
                                         same_bank_activate_interval};
          `SDRTP_OFF_RCD: o_read_data <= {26'h0000000, row_to_column_delay};
          `SDRTP_OFF_RFC: o_read_data <= {22'h000000, auto_refresh_cmd_time};
          `SDRTP_OFF_RP: o_read_data <= {26'h0000000,
                                         precharge_to_activate_delay};
          `SDRTP_OFF_RRD: o_read_data <= {28'h0000000,
                                          cross_bank_activate_interval};
          `SDRTP_OFF_WR: o_read_data <= {29'h00000000, write_recovery_delay};
          default: o_read_data <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_write_strobe_delay = write_strobe_delay;

  // ----------------------------------------------------------------------
  // refresh interval
  // ----------------------------------------------------------------------

  // a zero period disables refresh; a write to the period restarts the
  // interval so a shortened period takes effect at once
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refresh_count <= `SDRTP_RST_REFRESH - 15'h0001;
    end else if (write_en && i_address == `SDRTP_OFF_REFRESH) begin
      refresh_count <= i_write_data[14:0] - 15'h0001;
    end else if (refresh_period == 15'h0000) begin
      refresh_count <= 15'h0000;
    end else if (refresh_count == 15'h0000) begin
      refresh_count <= refresh_period - 15'h0001;
    end else begin
      refresh_count <= refresh_count - 15'h0001;
    end
  end

  // request stays up until a refresh issues; a new tick wins over the clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refresh_pending <= 1'b0;
    end else if (refresh_period != 15'h0000 &&
                 refresh_count == 15'h0000) begin
      refresh_pending <= 1'b1;
    end else if (i_cmd.refresh) begin
      refresh_pending <= 1'b0;
    end
  end

  assign o_refresh_request = refresh_pending;

  // ----------------------------------------------------------------------
  // read latency
  // ----------------------------------------------------------------------

  // a zero latency cannot be honoured in a one-clock pipe, so it acts as one
  assign latency = read_latency_setting[`SDRTP_LAT_LSB +: 3];
  assign capture_index = (latency == 3'h0) ? 3'h0 : latency - 3'h1;

  // the half offset is forced off in SDR and LPDDR modes
  assign next_half = read_latency_setting[`SDRTP_LAT_HALF_BIT] &&
                     (i_memory_type != `SDRTP_MEM_SDR) &&
                     (i_memory_type != `SDRTP_MEM_LPDDR);

  // one bit per cycle since the read; back to back reads overlap freely
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      read_pipe <= '0;
    end else begin
      read_pipe <= {read_pipe[`SDRTP_PIPE_LEN-2:0], i_cmd.read};
    end
  end

  // offset flag registered so the capture path sees a flop output
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      half_offset <= 1'b0;
    end else begin
      half_offset <= next_half;
    end
  end

  assign o_capture = read_pipe[capture_index];
  assign o_capture_half = half_offset;

  // ----------------------------------------------------------------------
  // global spacing counters
  // ----------------------------------------------------------------------

  assign load_rcd_sched = 8'(row_to_column_delay[`SDRTP_RCD_SCHED_LSB +: 3])
                          + `SDRTP_SCHED_BIAS;
  assign load_rp_sched =
    8'(precharge_to_activate_delay[`SDRTP_RP_SCHED_LSB +: 3])
    + `SDRTP_SCHED_BIAS;
  assign load_rfc_sched = 8'(auto_refresh_cmd_time[`SDRTP_RFC_SCHED_LSB +: 5])
                          + `SDRTP_SCHED_BIAS;

  // mode register command blocks every following command
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mrd_cnt <= 8'h00;
    end else if (i_cmd.mode_reg) begin
      mrd_cnt <= span(8'(mode_reg_cmd_time));
    end else begin
      mrd_cnt <= dec(mrd_cnt);
    end
  end

  // auto-refresh blocks every following command, in both time bases
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rfc_cnt <= 8'h00;
      sched_rfc_cnt <= 8'h00;
    end else if (i_cmd.refresh) begin
      rfc_cnt <= span(8'(auto_refresh_cmd_time[4:0]));
      sched_rfc_cnt <= span(load_rfc_sched);
    end else begin
      rfc_cnt <= dec(rfc_cnt);
      sched_rfc_cnt <= dec(sched_rfc_cnt);
    end
  end

  // any activate holds off activates to every bank
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rrd_cnt <= 8'h00;
    end else if (i_cmd.activate) begin
      rrd_cnt <= span(8'(cross_bank_activate_interval));
    end else begin
      rrd_cnt <= dec(rrd_cnt);
    end
  end

  assign o_gate.any_ok = (mrd_cnt == 8'h00) && (rfc_cnt == 8'h00);
  assign o_gate.sched_any_ok = (mrd_cnt == 8'h00) &&
                               (sched_rfc_cnt == 8'h00);

  // ----------------------------------------------------------------------
  // per-bank spacing counters
  // ----------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < `SDRTP_BANKS; b++) begin : g_bank
      logic hit;
      logic act_hit;
      logic pre_hit;
      logic [7:0] ras_cnt;
      logic [7:0] rc_cnt;
      logic [7:0] rcd_cnt;
      logic [7:0] sched_rcd_cnt;
      logic [7:0] rp_cnt;
      logic [7:0] sched_rp_cnt;
      logic [7:0] wr_cnt;

      assign hit = (i_cmd.bank == 2'(b));
      assign act_hit = i_cmd.activate && hit;
      assign pre_hit = (i_cmd.precharge && hit) || i_cmd.precharge_all;

      // row open time and same-bank activate cycle, both from activate
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          ras_cnt <= 8'h00;
          rc_cnt <= 8'h00;
        end else if (act_hit) begin
          ras_cnt <= span(8'(activate_to_precharge_min));
          rc_cnt <= span(8'(same_bank_activate_interval));
        end else begin
          ras_cnt <= dec(ras_cnt);
          rc_cnt <= dec(rc_cnt);
        end
      end

      // activate to column, memory count and biased schedule count
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          rcd_cnt <= 8'h00;
          sched_rcd_cnt <= 8'h00;
        end else if (act_hit) begin
          rcd_cnt <= span(8'(row_to_column_delay[2:0]));
          sched_rcd_cnt <= span(load_rcd_sched);
        end else begin
          rcd_cnt <= dec(rcd_cnt);
          sched_rcd_cnt <= dec(sched_rcd_cnt);
        end
      end

      // precharge to activate, memory count and biased schedule count
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          rp_cnt <= 8'h00;
          sched_rp_cnt <= 8'h00;
        end else if (pre_hit) begin
          rp_cnt <= span(8'(precharge_to_activate_delay[2:0]));
          sched_rp_cnt <= span(load_rp_sched);
        end else begin
          rp_cnt <= dec(rp_cnt);
          sched_rp_cnt <= dec(sched_rp_cnt);
        end
      end

      // write recovery starts at the last data beat, not the command,
      // since burst length is not known here
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          wr_cnt <= 8'h00;
        end else if (i_cmd.write_last && hit) begin
          wr_cnt <= span(8'(write_recovery_delay));
        end else begin
          wr_cnt <= dec(wr_cnt);
        end
      end

      // dependent commands wait for every governing counter to reach zero
      assign o_gate.activate_ok[b] = o_gate.any_ok && (rc_cnt == 8'h00) &&
                                     (rp_cnt == 8'h00) &&
                                     (rrd_cnt == 8'h00);
      assign o_gate.column_ok[b] = o_gate.any_ok &&
                                   (rcd_cnt == 8'h00);
      assign o_gate.precharge_ok[b] = o_gate.any_ok && (ras_cnt == 8'h00) &&
                                      (wr_cnt == 8'h00);
      assign o_gate.sched_activate_ok[b] = o_gate.sched_any_ok &&
                                           (sched_rp_cnt == 8'h00);
      assign o_gate.sched_column_ok[b] = o_gate.sched_any_ok &&
                                         (sched_rcd_cnt == 8'h00);
    end
  endgenerate

endmodule
`default_nettype wire

// File: verif/sdrtp_timing_props.sv
// Checker for the timing parameter set, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sdrtp_timing_props (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_address,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [31:0] o_read_data,
  input wire sdrtp_pkg::sdrtp_ctrl_state_t i_ctrl_state,
  input wire logic [2:0] i_memory_type,
  input wire sdrtp_pkg::sdrtp_cmd_t i_cmd,
  input wire sdrtp_pkg::sdrtp_gate_t o_gate,
  input wire logic o_capture,
  input wire logic o_capture_half,
  input wire logic [1:0] o_write_strobe_delay
);
  logic blocked;
  // states in which the timing registers are out of reach
  assign blocked = i_ctrl_state == sdrtp_pkg::SDRTP_ST_READY ||
    i_ctrl_state == sdrtp_pkg::SDRTP_ST_PAUSED;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence refused_read_s;
    i_read && blocked && i_address >= 8'h10 && i_address <= 8'h38;
  endsequence
  sequence narrow_type_s;
    i_memory_type == 3'h0 || i_memory_type == 3'h3;
  endsequence
  // the bank is taken from the pulse cycle, as the sequencer drops it after
  sequence rcd_hold_s;
    !o_gate.sched_column_ok[$past(i_cmd.bank)] ##1
    !o_gate.sched_column_ok[$past(i_cmd.bank, 2)];
  endsequence
  read_idle_zero_a: assert property (!$past(i_read) |-> o_read_data == 32'h0)
    else $error("read data outside its answer cycle");
  refused_read_a: assert property (refused_read_s |=> o_read_data == 32'h0)
    else $error("timing register readable in a busy state");
  refused_write_a: assert property (i_write && blocked |=>
    $stable(o_write_strobe_delay) ##1 ($stable(o_write_strobe_delay) ||
    $past(i_write))) else $error("write taken in a busy state");
  half_forced_a: assert property (narrow_type_s [*2] |-> !o_capture_half)
    else $error("half offset not forced off");
  capture_after_a: assert property (i_cmd.read |-> ##[1:7] o_capture)
    else $error("no capture within the latency range");
  gates_open_a: assert property ($rose(i_reset_n) |-> &o_gate)
    else $error("gate closed after reset");
  any_gate_a: assert property (!o_gate.any_ok |-> o_gate.activate_ok == 4'h0
    && o_gate.column_ok == 4'h0 && o_gate.precharge_ok == 4'h0)
    else $error("bank gate open under a global hold");
  sched_gate_a: assert property (!o_gate.sched_any_ok |->
    o_gate.sched_activate_ok == 4'h0 && o_gate.sched_column_ok == 4'h0)
    else $error("schedule gate open under a global hold");
  sched_rfc_a: assert property (i_cmd.refresh |=> (!o_gate.sched_any_ok) [*2])
    else $error("schedule refresh hold under three");
  sched_rp_a: assert property (i_cmd.precharge_all |=>
    (o_gate.sched_activate_ok == 4'h0) [*2])
    else $error("schedule precharge hold under three");
  sched_rcd_a: assert property (i_cmd.activate |=> rcd_hold_s)
    else $error("schedule column hold under three");
endmodule
bind sdrtp_timing sdrtp_timing_props u_props (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_address(i_address), .i_write(i_write),
  .i_read(i_read), .o_read_data(o_read_data), .i_ctrl_state(i_ctrl_state),
  .i_memory_type(i_memory_type), .i_cmd(i_cmd), .o_gate(o_gate),
  .o_capture(o_capture), .o_capture_half(o_capture_half),
  .o_write_strobe_delay(o_write_strobe_delay));
`default_nettype wire

// File: verif/sdrtp_seq_model.sv
// Sequencer stand-in: issues one command once its permission level allows.
// Assumes the gate levels of the timing block on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sdrtp_seq_model (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_go,
  input wire logic [2:0] i_kind,
  input wire logic [1:0] i_bank,
  input wire sdrtp_pkg::sdrtp_gate_t i_gate,
  output var sdrtp_pkg::sdrtp_cmd_t o_cmd
);
  logic pending;
  logic [2:0] kind;
  logic [1:0] bank;
  logic allowed;
  // permission for the held command; kinds follow the command bit order
  always_comb begin
    case (kind)
      3'h0: allowed = i_gate.activate_ok[bank];
      3'h1, 3'h2: allowed = i_gate.column_ok[bank];
      3'h3: allowed = i_gate.precharge_ok[bank];
      3'h4: allowed = &i_gate.precharge_ok;
      default: allowed = i_gate.any_ok;
    endcase
  end
  // never issues against a closed gate; the pulse lasts one cycle
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pending <= 1'b0;
      kind <= 3'h0;
      bank <= 2'h0;
      o_cmd <= '0;
    end else begin
      o_cmd <= '0;
      if (pending && allowed) begin
        o_cmd <= sdrtp_pkg::sdrtp_cmd_t'((9'h100 >> kind) | {7'h00, bank});
        pending <= 1'b0;
      end else if (i_go) begin
        pending <= 1'b1;
        kind <= i_kind;
        bank <= i_bank;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_sdrtp_timing.sv
// Self-checking bench for the timing parameter set and a sequencer model.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("wrong value at %0t: %h not %h", $time, got, exp); \
  end end
module tb_sdrtp_timing;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic write = 1'b0;
  logic read = 1'b0;
  logic [31:0] rdata;
  sdrtp_pkg::sdrtp_ctrl_state_t state = sdrtp_pkg::SDRTP_ST_CONFIG;
  logic [2:0] mem_type = 3'h1;
  sdrtp_pkg::sdrtp_cmd_t cmd;
  sdrtp_pkg::sdrtp_gate_t gate;
  logic refresh_req;
  logic capture;
  logic capture_half;
  logic [1:0] strobe_delay;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [1:0] bank = 2'h0;
  logic [24:0] obs;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 32'h8D8B539C;
  int cycles = 0;
  realtime rise_t = 0;
  logic [31:0] rst_v [11] = '{32'hA60, 32'h6, 32'h1, 32'h2, 32'h7, 32'hB,
    32'h1D, 32'h212, 32'h1D, 32'h2, 32'h3};
  logic [31:0] msk_v [11] = '{32'h7FFF, 32'hF, 32'h3, 32'h7F, 32'hF, 32'hF,
    32'h3F, 32'h3FF, 32'h3F, 32'hF, 32'h7};
  // spacing table: register, field shift, largest value, bias, command, bank
  int sp_addr [11] = '{28, 32, 36, 52, 40, 40, 44, 44, 48, 48, 56};
  int sp_sh [11] = '{0, 0, 0, 0, 0, 3, 0, 5, 0, 3, 0};
  int sp_max [11] = '{31, 15, 15, 15, 7, 7, 31, 31, 7, 7, 7};
  int sp_bias [11] = '{0, 0, 0, 0, 0, 3, 0, 3, 0, 3, 0};
  int sp_kind [11] = '{6, 0, 0, 0, 0, 0, 5, 5, 3, 4, 2};
  int sp_bank [11] = '{0, 0, 0, 0, 2, 2, 0, 0, 1, 1, 3};
  int sp_pos [11] = '{21, 8, 16, 17, 14, 2, 21, 20, 17, 5, 11};
  // observed bits: all gates open, refresh request, capture, gate levels
  assign obs = {&gate, refresh_req, capture, gate};
  sdrtp_timing dut (.i_clock(clock), .i_reset_n(reset_n), .i_address(address),
    .i_write_data(wdata), .i_write(write), .i_read(read), .o_read_data(rdata),
    .i_ctrl_state(state), .i_memory_type(mem_type), .i_cmd(cmd), .o_gate(gate),
    .o_refresh_request(refresh_req), .o_capture(capture),
    .o_capture_half(capture_half), .o_write_strobe_delay(strobe_delay));
  sdrtp_seq_model u_seq (.i_clock(clock), .i_reset_n(reset_n), .i_go(go),
    .i_kind(kind), .i_bank(bank), .i_gate(gate), .o_cmd(cmd));
  always #5 clock = ~clock;
  // the period is read off the time between two rises of the request
  always @(posedge refresh_req) rise_t = $realtime;
  // a hang is cut short well past the expected length of the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    write <= 1'b1;
    address <= a;
    wdata <= d;
    @(posedge clock);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    read <= 1'b1;
    address <= a;
    @(posedge clock);
    read <= 1'b0;
    #1;
    d = rdata;
  endtask
  // counts edges until the chosen bit is high; bounded by 300
  task automatic span(input int pos, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (obs[pos] !== 1'b1 && n < 300);
  endtask
  // returns in the cycle that holds the command pulse
  task automatic issue(input int k, input int b);
    int w;
    @(posedge clock);
    go <= 1'b1;
    kind <= 3'(k);
    bank <= 2'(b);
    @(posedge clock);
    go <= 1'b0;
    span(24, w);
    w = 0;
    while (cmd[8:2] == 7'h00 && w < 300) begin
      @(posedge clock);
      #1;
      w++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    logic [31:0] got;
    logic [31:0] r;
    logic [31:0] last;
    int n;
    int f;
    int i;
    realtime t1;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    for (i = 0; i < 11; i++) begin
      rd(8'h10 + 8'(4 * i), got);
      `CHK(got, rst_v[i])
    end
    rd(8'h80, got);
    `CHK(got, 32'h6)
    last = 32'h2;
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      @(posedge clock);
      state <= sdrtp_pkg::sdrtp_ctrl_state_t'(i);
      wr(8'h34, r);
      rd(8'h34, got);
      if (i == 0 || i == 3) last = r & 32'hF;
      `CHK(got, (i == 0 || i == 3) ? last : 32'h0)
      @(posedge clock);
      state <= sdrtp_pkg::SDRTP_ST_CONFIG;
      rd(8'h34, got);
      `CHK(got, last)
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, got);
    `CHK(got, 32'h0)
    wr(8'h34, 32'h2);
    for (i = 0; i < 11; i++) begin
      f = 2 + ($unsigned($random(seed)) % (sp_max[i] - 1));
      wr(8'(sp_addr[i]), 32'(f) << sp_sh[i]);
      issue(sp_kind[i], sp_bank[i]);
      span(sp_pos[i], n);
      `CHK(n, f + sp_bias[i])
    end
    for (i = 1; i < 8; i++) begin
      wr(8'h14, 32'(i) << 1);
      issue(1, 0);
      span(22, n);
      `CHK(n, i)
    end
    for (i = 0; i < 8; i++) begin
      wr(8'h14, 32'h6 | 32'(i / 4));
      mem_type <= 3'(i % 4);
      repeat (3) @(posedge clock);
      #1;
      `CHK(capture_half, i > 4 && i != 7)
    end
    f = 10 + ($unsigned($random(seed)) % 30);
    wr(8'h2C, 32'h0);
    wr(8'h10, 32'(f));
    issue(5, 0);
    span(23, n);
    t1 = rise_t;
    issue(5, 0);
    @(posedge clock);
    #1;
    `CHK(refresh_req, 1'b0)
    span(23, n);
    `CHK(int'((rise_t - t1) / 10.0), f)
    for (i = 0; i < 16; i++) begin
      f = (i == 0) ? 2 : $unsigned($random(seed)) % 11;
      r = $random(seed);
      wr(8'h10 + 8'(4 * f), r);
      rd(8'h10 + 8'(4 * f), got);
      `CHK(got, r & msk_v[f])
      if (f == 2) `CHK(strobe_delay, r[1:0])
    end
    test_done();
  end
endmodule
`default_nettype wire
